/* common/tsw_if.sv */
/*
  Two-wire link between bus master and sensor end.
  Assumes open-drain data with a pull-up; the master alone drives the clock.
*/
`timescale 1ns/100ps
interface tsw_if;
  logic scl;
  logic sda_m_out;
  logic sda_m_oe_n;
  logic sda_s_out;
  logic sda_s_oe_n;
  logic sda_in;

  // wired-and data line, pulled high when nobody drives
  assign sda_in = (sda_m_oe_n | sda_m_out) & (sda_s_oe_n | sda_s_out);

  modport slave (input scl, input sda_in, output sda_s_out, output sda_s_oe_n);
  modport master (output scl, output sda_m_out, output sda_m_oe_n, input sda_in);
endinterface

/* common/tsw_pkg.sv */
/*
  Shared constants and types for both ends of the two-wire temperature
  sensor link. Assumes one 100 MHz system clock at each end.
*/
package tsw_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_QTR_NS    = 650;
  localparam int SCL_QTR_CYC   = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // addressing and command bytes
  // ****************************************
  localparam logic [3:0] DEV_CODE_DFLT = 4'hA;   // arbitrary value
  localparam logic [7:0] GC_BYTE       = 8'h00;
  localparam logic [7:0] GC_RELOAD     = 8'h04;
  localparam logic [7:0] GC_RESET      = 8'h06;

  // ****************************************
  // registers
  // ****************************************
  localparam logic [7:0] PTR_TEMP    = 8'h00;
  localparam logic [7:0] PTR_CFG     = 8'h01;
  localparam logic [7:0] PTR_RST     = PTR_TEMP;
  localparam logic [7:0] CFG_RST     = 8'h00;
  localparam int         TEMP_W      = 12;
  localparam logic [11:0] TEMP_ZERO  = 12'h000;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  // ****************************************
  // bit counting and sequencing
  // ****************************************
  localparam logic [3:0] CNT_ZERO     = 4'h0;
  localparam logic [3:0] CNT_ONE      = 4'h1;
  localparam logic [3:0] BIT_LAST     = 4'h7;
  localparam logic [3:0] BIT_ACK      = 4'h8;
  localparam logic [1:0] LINE_IDLE    = 2'h3;
  localparam logic [1:0] ADDR_LD_WAIT = 2'h3;
  localparam logic [1:0] ADDR_LD_NOW  = 2'h1;
  localparam logic [1:0] ADDR_LD_DONE = 2'h0;
  localparam logic [1:0] ADDR_LD_STEP = 2'h1;
  localparam logic [1:0] PH_SET       = 2'h0;
  localparam logic [1:0] PH_RISE      = 2'h1;
  localparam logic [1:0] PH_MID       = 2'h2;
  localparam logic [1:0] PH_STEP      = 2'h1;
  localparam logic [1:0] REL_NONE     = 2'h0;
  localparam logic [1:0] REL_CLK      = 2'h1;
  localparam logic [1:0] REL_START2   = 2'h2;
  localparam logic [1:0] REL_STOP     = 2'h3;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {PIN_LO, PIN_HI, PIN_OPEN} tsw_pin_t;
  typedef enum logic [2:0] {OP_START, OP_STOP, OP_WRITE, OP_READ, OP_RELEASE} tsw_op_t;

endpackage

/* src/tsw_master.sv */
/*
  Bus master end of the two-wire link: start, stop, byte write, byte read
  and the bus-release sequence, one operation per request.
  Assumes the user composes transfers from these operations.
*/
`timescale 1ns/100ps
module tsw_master (
  // system
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // two-wire link
  tsw_if.master                 bus,
  // operation request
  input  wire logic             op_valid,
  input  wire tsw_pkg::tsw_op_t op_code,
  input  wire logic [7:0]       op_byte,
  input  wire logic             op_last,
  output logic                  op_ready,
  // operation result
  output logic                  op_done,
  output logic      [7:0]       rd_data,
  output logic                  ack_seen
);
  import tsw_pkg::*;

  typedef enum {MS_IDLE, MS_START, MS_BIT, MS_STOP} tsw_mst_t;
  localparam int QW = $clog2(SCL_QTR_CYC);

  tsw_mst_t  st_q;
  tsw_op_t   op_q;
  logic [QW-1:0] qcnt_q;
  logic [1:0] ph_q;
  logic [1:0] rel_q;
  logic [3:0] cnt_q;
  logic [7:0] byte_q;
  logic [7:0] rd_q;
  logic       last_q;
  logic       scl_q;
  logic       oe_n_q;
  logic       ready_q;
  logic       done_q;
  logic       ack_q;
  logic       sda_s;
  logic       tick;
  logic       bit_val;
  logic       finish;

  // ****************************************
  // data pin sampling and clock divider
  // ****************************************
  tsw_sync #(
    .W       (1),
    .RST_VAL (1'h1)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .d_in    (bus.sda_in),
    .d_out   (sda_s)
  );

  // quarter-period enable
  always_ff @(posedge clk_sys) begin
    if (!reset_n || tick)
      qcnt_q <= '0;
    else
      qcnt_q <= qcnt_q + QW'(1);
  end

  assign tick   = (qcnt_q == QW'(SCL_QTR_CYC - 1));
  assign finish = tick && ph_q == PH_SET - PH_STEP
                  && (st_q != MS_BIT || cnt_q == BIT_ACK);

  // level to leave on the data line for the current bit
  always_comb begin
    case (op_q)
      OP_WRITE: bit_val = (cnt_q == BIT_ACK) | byte_q[7];
      OP_READ:  bit_val = (cnt_q != BIT_ACK) | last_q;
      default:  bit_val = 1'b1;
    endcase
  end

  // ****************************************
  // operation sequencer
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q    <= MS_IDLE;
      op_q    <= OP_START;
      ph_q    <= PH_SET;
      rel_q   <= REL_NONE;
      cnt_q   <= CNT_ZERO;
      byte_q  <= BYTE_ZERO;
      rd_q    <= BYTE_ZERO;
      last_q  <= 1'b0;
      scl_q   <= 1'b1;
      oe_n_q  <= 1'b1;
      ready_q <= 1'b1;
      done_q  <= 1'b0;
      ack_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        MS_IDLE: if (op_valid && ready_q) begin
          ready_q <= 1'b0;
          op_q    <= op_code;
          byte_q  <= op_byte;
          last_q  <= op_last;
          ph_q    <= PH_SET;
          cnt_q   <= CNT_ZERO;
          rel_q   <= REL_NONE;
          case (op_code)
            OP_STOP:          st_q <= MS_STOP;
            OP_WRITE, OP_READ: st_q <= MS_BIT;
            OP_RELEASE: begin
              st_q  <= MS_START;
              rel_q <= REL_CLK;
            end
            default:          st_q <= MS_START;
          endcase
        end
        default: if (tick) begin
          ph_q <= ph_q + PH_STEP;
          case (ph_q)
            PH_SET:  oe_n_q <= (st_q == MS_BIT) ? bit_val : (st_q == MS_START);
            PH_RISE: scl_q <= 1'b1;
            PH_MID: begin
              if (st_q == MS_START)
                oe_n_q <= 1'b0;
              else if (st_q == MS_STOP)
                oe_n_q <= 1'b1;
              else if (cnt_q == BIT_ACK)
                ack_q <= ~sda_s;
              else if (op_q == OP_READ)
                byte_q <= {byte_q[6:0], sda_s};
            end
            default: begin
              if (st_q != MS_STOP)
                scl_q <= 1'b0;
              if (st_q == MS_BIT && cnt_q != BIT_ACK) begin
                cnt_q <= cnt_q + CNT_ONE;
                if (op_q == OP_WRITE)
                  byte_q <= {byte_q[6:0], 1'b0};
              end
              if (finish) begin
                case (rel_q)
                  REL_CLK: begin
                    st_q  <= MS_BIT;
                    cnt_q <= CNT_ZERO;
                    rel_q <= REL_START2;
                  end
                  REL_START2: begin
                    st_q  <= MS_START;
                    rel_q <= REL_STOP;
                  end
                  REL_STOP: begin
                    st_q  <= MS_STOP;
                    rel_q <= REL_NONE;
                  end
                  default: begin
                    st_q    <= MS_IDLE;
                    ready_q <= 1'b1;
                    done_q  <= 1'b1;
                    if (op_q == OP_READ)
                      rd_q <= byte_q;
                  end
                endcase
              end
            end
          endcase
        end
      endcase
    end
  end

  // outputs; the data pin only ever pulls low
  assign bus.scl        = scl_q;
  assign bus.sda_m_out  = 1'b0;
  assign bus.sda_m_oe_n = oe_n_q;
  assign op_ready       = ready_q;
  assign op_done        = done_q;
  assign rd_data        = rd_q;
  assign ack_seen       = ack_q;
endmodule

/* src/tsw_slave.sv */
/*
  Sensor end of the two-wire link: address match, pointer, configuration
  register, temperature reads and general call.
  Assumes temp_data comes from a conversion engine on clk_sys.
*/
`timescale 1ns/100ps
module tsw_slave #(
  parameter logic [3:0] DEV_CODE = tsw_pkg::DEV_CODE_DFLT
) (
  // system
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  // two-wire link
  tsw_if.slave                          bus,
  // address straps
  input  wire tsw_pkg::tsw_pin_t        addr_select_hi_pin,
  input  wire tsw_pkg::tsw_pin_t        addr_select_lo_pin,
  // conversion side
  input  wire logic [tsw_pkg::TEMP_W-1:0] temp_data,
  input  wire logic                     temp_valid,
  output logic      [7:0]               cfg_value,
  output logic      [2:0]               own_addr,
  output logic                          gc_reset_pulse
);
  import tsw_pkg::*;

  typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} tsw_sst_t;
  typedef enum {RB_ADDR, RB_PTR, RB_DATA, RB_GC} tsw_role_t;

  tsw_sst_t    st_q;
  tsw_role_t   role_q;
  logic [3:0]  cnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  tx_q;
  logic [7:0]  ptr_q;
  logic [7:0]  cfg_q;
  logic [7:0]  wr_data_q;
  logic        rw_q;
  logic        ack_q;
  logic        mack_q;
  logic        idx_q;
  logic        oe_n_q;
  logic        wr_pend_q;
  logic        gc_rst_q;
  logic [1:0]  ld_cnt_q;
  logic [2:0]  own_addr_q;
  logic        scl_p_q;
  logic        sda_p_q;
  logic [5:0]  sync_out;
  logic        scl_s;
  logic        sda_s;
  tsw_pin_t    pin_hi;
  tsw_pin_t    pin_lo;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_ev;
  logic        stop_ev;
  logic        last_rx;
  logic        ack_end;
  logic        rst_all;
  logic        rx_ack;
  logic [7:0]  byte_in;
  logic [15:0] temp_word;
  logic [7:0]  rd_first;
  logic [7:0]  rd_next;

  // strap decode: hi selects the top bit unless open
  function automatic logic [2:0] pins_to_addr(tsw_pin_t hi, tsw_pin_t lo);
    case (hi)
      PIN_LO:  pins_to_addr = {1'b0, lo == PIN_HI, lo == PIN_OPEN};
      PIN_HI:  pins_to_addr = {1'b1, lo == PIN_HI, lo == PIN_OPEN};
      default: pins_to_addr = {lo == PIN_HI, 2'h3};
    endcase
  endfunction

  // byte to send for the current pointer
  function automatic logic [7:0] rd_byte(logic second);
    if (ptr_q == PTR_CFG)
      rd_byte = cfg_q;
    else if (second)
      rd_byte = temp_word[7:0];
    else
      rd_byte = temp_word[15:8];
  endfunction

  // ****************************************
  // pin sampling and link conditions
  // ****************************************
  tsw_sync #(
    .W       (6),
    .RST_VAL (6'h3F)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .d_in    ({bus.scl, bus.sda_in, addr_select_hi_pin, addr_select_lo_pin}),
    .d_out   (sync_out)
  );

  assign scl_s  = sync_out[5];
  assign sda_s  = sync_out[4];
  assign pin_hi = tsw_pin_t'(sync_out[3:2]);
  assign pin_lo = tsw_pin_t'(sync_out[1:0]);

  // previous line levels for edge finding
  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      {scl_p_q, sda_p_q} <= LINE_IDLE;
    else
      {scl_p_q, sda_p_q} <= {scl_s, sda_s};
  end

  // edges and bus conditions
  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign start_ev  = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev   = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign byte_in   = {shift_q[6:0], sda_s};
  assign last_rx   = (st_q == ST_RX) && scl_rise && (cnt_q == BIT_LAST);
  assign ack_end   = (st_q == ST_ACK) && scl_fall && (cnt_q != BIT_ACK);
  assign rst_all   = ~reset_n | gc_rst_q;
  assign temp_word = {temp_valid ? temp_data : TEMP_ZERO, NIBBLE_ZERO};
  assign rd_first  = rd_byte(1'b0);
  assign rd_next   = rd_byte(~idx_q);

  // ack decision for the byte now ending
  always_comb begin
    case (role_q)
      RB_ADDR: rx_ack = (byte_in[7:1] == {DEV_CODE, own_addr_q})
                        || (byte_in == GC_BYTE);
      RB_GC:   rx_ack = (byte_in == GC_RELOAD) || (byte_in == GC_RESET);
      default: rx_ack = 1'b1;
    endcase
  end

  // ****************************************
  // transfer sequencer
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      st_q   <= ST_IDLE;
      role_q <= RB_ADDR;
      cnt_q  <= CNT_ZERO;
      shift_q <= BYTE_ZERO;
      tx_q   <= BYTE_ZERO;
      rw_q   <= 1'b0;
      ack_q  <= 1'b0;
      mack_q <= 1'b0;
      idx_q  <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (start_ev) begin
      st_q   <= ST_RX;
      role_q <= RB_ADDR;
      cnt_q  <= CNT_ZERO;
      mack_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (stop_ev) begin
      st_q   <= ST_IDLE;
      oe_n_q <= 1'b1;
    end else begin
      case (st_q)
        ST_RX: if (scl_rise) begin
          shift_q <= byte_in;
          cnt_q   <= cnt_q + CNT_ONE;
          if (cnt_q == BIT_LAST) begin
            st_q  <= ST_ACK;
            ack_q <= rx_ack;
            if (role_q == RB_ADDR)
              rw_q <= byte_in[0];
          end
        end
        ST_ACK: if (scl_fall) begin
          if (cnt_q == BIT_ACK) begin
            oe_n_q <= ~ack_q;
            cnt_q  <= cnt_q + CNT_ONE;
          end else begin
            oe_n_q <= 1'b1;
            cnt_q  <= CNT_ZERO;
            st_q   <= ST_RX;
            if (!ack_q)
              st_q <= ST_IDLE;
            else begin
              case (role_q)
                RB_ADDR: if (shift_q == GC_BYTE)
                  role_q <= RB_GC;
                else if (rw_q) begin
                  st_q   <= ST_TX;
                  idx_q  <= 1'b0;
                  oe_n_q <= rd_first[7];
                  tx_q   <= {rd_first[6:0], 1'b0};
                end else
                  role_q <= RB_PTR;
                RB_PTR:  role_q <= RB_DATA;
                RB_GC:   st_q <= ST_IDLE;
                default: role_q <= RB_DATA;
              endcase
            end
          end
        end
        ST_TX: if (scl_rise)
          cnt_q <= cnt_q + CNT_ONE;
        else if (scl_fall) begin
          if (cnt_q == BIT_ACK) begin
            oe_n_q <= 1'b1;
            st_q   <= ST_TXACK;
          end else begin
            oe_n_q <= tx_q[7];
            tx_q   <= {tx_q[6:0], 1'b0};
          end
        end
        ST_TXACK: if (scl_rise) begin
          if (sda_s)
            st_q <= ST_IDLE;
          else
            mack_q <= 1'b1;
        end else if (scl_fall && mack_q) begin
          mack_q <= 1'b0;
          idx_q  <= ~idx_q;
          cnt_q  <= CNT_ZERO;
          st_q   <= ST_TX;
          oe_n_q <= rd_next[7];
          tx_q   <= {rd_next[6:0], 1'b0};
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // pointer and configuration register
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      ptr_q     <= PTR_RST;
      cfg_q     <= CFG_RST;
      wr_pend_q <= 1'b0;
      wr_data_q <= BYTE_ZERO;
    end else begin
      if (last_rx && role_q == RB_PTR)
        ptr_q <= byte_in;
      if (start_ev)
        wr_pend_q <= 1'b0;
      else if (stop_ev) begin
        wr_pend_q <= 1'b0;
        if (wr_pend_q && ptr_q == PTR_CFG)
          cfg_q <= wr_data_q;
      end else if (last_rx && role_q == RB_DATA) begin
        wr_pend_q <= 1'b1;
        wr_data_q <= byte_in;
      end
    end
  end

  // ****************************************
  // own address and general call effects
  // ****************************************
  // strap capture waits for the synchroniser to fill
  always_ff @(posedge clk_sys) begin
    if (rst_all)
      ld_cnt_q <= ADDR_LD_WAIT;
    else if (ack_end && ack_q && role_q == RB_GC && shift_q == GC_RELOAD)
      ld_cnt_q <= ADDR_LD_NOW;
    else if (ld_cnt_q != ADDR_LD_DONE)
      ld_cnt_q <= ld_cnt_q - ADDR_LD_STEP;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      own_addr_q <= 3'h0;
    else if (ld_cnt_q == ADDR_LD_NOW)
      own_addr_q <= pins_to_addr(pin_hi, pin_lo);
  end

  // one-cycle soft reset after the reset byte is acked
  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      gc_rst_q <= 1'b0;
    else
      gc_rst_q <= ack_end && ack_q && role_q == RB_GC && shift_q == GC_RESET;
  end

  // outputs; the data pin only ever pulls low
  assign bus.sda_s_out   = 1'b0;
  assign bus.sda_s_oe_n  = oe_n_q;
  assign cfg_value       = cfg_q;
  assign own_addr        = own_addr_q;
  assign gc_reset_pulse  = gc_rst_q;
endmodule

/* src/tsw_sync.sv */
/*
  Two-flop synchroniser for pin inputs.
  Assumes the inputs are slow compared with clk_sys.
*/
`timescale 1ns/100ps
module tsw_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // system
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign d_out = sync_q;
endmodule

/* tb/test_temp_sensor_two_wire_slave.sv */
/*
  Self-checking bench joining master and sensor ends over one link.
  Assumes both ends share clk_sys and the default device code.
*/
`timescale 1ns/100ps
module test_temp_sensor_two_wire_slave;
  import tsw_pkg::*;

  localparam logic [7:0] AW = {DEV_CODE_DFLT, 3'h7, 1'b0};
  localparam logic [7:0] AR = AW | 8'h01;

  logic        clk_sys    = 1'b0;
  logic        reset_n    = 1'b0;
  logic        op_valid   = 1'b0;
  tsw_op_t     op_code    = OP_START;
  logic [7:0]  op_byte    = 8'h00;
  logic        op_last    = 1'b0;
  tsw_pin_t    hi         = PIN_LO;
  tsw_pin_t    lo         = PIN_LO;
  logic [11:0] temp_data  = 12'hFFC;
  logic        temp_valid = 1'b0;
  logic        gc_seen    = 1'b0;
  logic [8:0]  wire_q     = 9'h000;
  logic        op_ready, op_done, ack_seen, gc_reset_pulse;
  logic [7:0]  rd_data, cfg_value;
  logic [2:0]  own_addr;
  int          cyc        = 0;
  int          num_errors = 0;
  int          num_checks = 0;
  // strap rows: {hi pin, lo pin, expected address bits}
  logic [6:0]  rows [8]   = '{7'h00, 7'h11, 7'h0A, 7'h24, 7'h35, 7'h2E, 7'h43, 7'h4F};

  tsw_if bus_if ();
  tsw_slave #(.DEV_CODE(DEV_CODE_DFLT)) i_tsw_slave (.clk_sys, .reset_n, .bus(bus_if),
    .addr_select_hi_pin(hi), .addr_select_lo_pin(lo), .temp_data, .temp_valid,
    .cfg_value, .own_addr, .gc_reset_pulse);
  tsw_master i_tsw_master (.clk_sys, .reset_n, .bus(bus_if), .op_valid, .op_code,
    .op_byte, .op_last, .op_ready, .op_done, .rd_data, .ack_seen);
  tsw_assertions i_tsw_assertions (.clk_sys, .reset_n, .scl(bus_if.scl),
    .sda_m_oe_n(bus_if.sda_m_oe_n), .sda_s_oe_n(bus_if.sda_s_oe_n), .sda_in(bus_if.sda_in));

  always #5 clk_sys = ~clk_sys;

  // sticky reset flag and wire capture at each clock rise
  always @(posedge clk_sys) if (gc_reset_pulse === 1'b1) gc_seen <= 1'b1;
  always @(posedge bus_if.scl) wire_q <= {wire_q[7:0], bus_if.sda_in};

  // watchdog over the whole run
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one master operation, held until taken, then wait for its end
  task automatic op(input tsw_op_t c, input logic [7:0] b, input logic l);
    @(negedge clk_sys);
    op_code = c;
    op_byte = b;
    op_last = l;
    op_valid = 1'b1;
    // ready is looked at between edges, where it has settled
    while (op_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    op_valid = 1'b0;
    while (op_done !== 1'b1) @(negedge clk_sys);
  endtask

  task automatic st();
    op(OP_START, 8'h00, 1'b0);
  endtask

  task automatic sp();
    op(OP_STOP, 8'h00, 1'b0);
  endtask

  task automatic wr(input logic [7:0] b, input logic a);
    op(OP_WRITE, b, 1'b0);
    chk({7'h00, ack_seen}, {7'h00, a});
  endtask

  task automatic rd(input logic l, input logic [7:0] e);
    op(OP_READ, 8'h00, l);
    chk(rd_data, e);
  endtask

  task automatic tdone(input string s);
    $display("test %s finished", s);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(negedge clk_sys);
    chk(cfg_value, CFG_RST);
    chk({7'h00, bus_if.sda_in & bus_if.scl}, 8'h01);
    reset_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      hi = tsw_pin_t'(rows[i][6:5]);
      lo = tsw_pin_t'(rows[i][4:3]);
      reset_n = 1'b0;
      repeat (3) @(negedge clk_sys);
      reset_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      chk({5'h00, own_addr}, {5'h00, rows[i][2:0]});
    end
    tdone("strap decode");
    st();
    wr(AW, 1'b1);
    chk(wire_q[8:1], AW);
    wr(PTR_CFG, 1'b1);
    wr(8'h5A, 1'b1);
    chk(cfg_value, CFG_RST);
    sp();
    chk(cfg_value, 8'h5A);
    tdone("config write");
    st();
    wr(AR, 1'b1);
    rd(1'b1, 8'h5A);
    sp();
    tdone("current config read");
    temp_valid = 1'b1;
    st();
    wr(AW, 1'b1);
    wr(PTR_TEMP, 1'b1);
    st();
    wr(AR, 1'b1);
    rd(1'b0, 8'hFF);
    rd(1'b1, 8'hC0);
    sp();
    tdone("temperature read");
    temp_valid = 1'b0;
    st();
    wr(AR, 1'b1);
    rd(1'b1, BYTE_ZERO);
    sp();
    tdone("read before conversion");
    st();
    wr({DEV_CODE_DFLT, 3'h2, 1'b0}, 1'b0);
    wr(PTR_CFG, 1'b0);
    sp();
    st();
    wr({DEV_CODE_DFLT ^ 4'h1, 3'h7, 1'b0}, 1'b0);
    sp();
    tdone("address mismatch");
    st();
    wr(AW, 1'b1);
    wr(PTR_TEMP, 1'b1);
    wr(8'h33, 1'b1);
    sp();
    chk(cfg_value, 8'h5A);
    tdone("read-only write");
    st();
    wr(GC_BYTE, 1'b1);
    wr(8'h01, 1'b0);
    sp();
    hi = PIN_HI;
    lo = PIN_OPEN;
    st();
    wr(GC_BYTE, 1'b1);
    wr(GC_RELOAD, 1'b1);
    sp();
    repeat (4) @(negedge clk_sys);
    chk({5'h00, own_addr}, 8'h05);
    chk(cfg_value, 8'h5A);
    tdone("address reload");
    temp_valid = 1'b1;
    st();
    wr({DEV_CODE_DFLT, 3'h5, 1'b1}, 1'b1);
    op(OP_RELEASE, 8'h00, 1'b0);
    chk({7'h00, bus_if.sda_s_oe_n}, 8'h01);
    st();
    wr(GC_BYTE, 1'b1);
    wr(GC_RESET, 1'b1);
    sp();
    chk(cfg_value, CFG_RST);
    chk({7'h00, gc_seen}, 8'h01);
    tdone("bus release and reset");
    complete_run();
  end
endmodule

/* tb/tsw_assertions.sv */
/*
  Checker for the link between master and sensor ends.
  Assumes every link signal is sampled by clk_sys.
*/
`timescale 1ns/100ps
module tsw_assertions (
  // system
  input wire logic clk_sys,
  input wire logic reset_n,
  // link
  input wire logic scl,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_oe_n,
  input wire logic sda_in
);
  localparam int LOW_MAX = 2600;

  logic [11:0] low_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // length of the current slave pull-down, saturating
  always_ff @(posedge clk_sys) begin
    if (!reset_n || sda_s_oe_n) begin
      low_q <= 12'h000;
    end else if (low_q != 12'hFFF) begin
      low_q <= low_q + 12'h001;
    end
  end

  // ****************************************
  // link assertions
  // ****************************************
  chk_slave_after_fall: assert property (
    $changed(sda_s_oe_n) |-> !scl && !$past(scl, 2) && $past(scl, 8))
    else $error("slave data moved away from a clock fall");
  chk_data_high_hold: assert property (
    $rose(scl) |=> $stable(sda_in) [*8])
    else $error("data moved just after a clock rise");
  chk_ack_hold_low: assert property (
    $fell(sda_s_oe_n) |=> !sda_s_oe_n [*8])
    else $error("slave pull-down too short");
  chk_start_released: assert property (
    $fell(sda_in) && scl && $past(scl) |-> sda_s_oe_n)
    else $error("slave driving at a start");
  chk_drive_bounded: assert property (
    low_q <= LOW_MAX)
    else $error("slave holds data low too long");
  chk_master_frame: assert property (
    $changed(sda_m_oe_n) && scl |=> scl [*8])
    else $error("master clock moved after start or stop");
  chk_stop_idle: assert property (
    $rose(sda_in) && scl && $past(scl) |=> scl [*8])
    else $error("clock moved after stop");
  chk_clock_low_time: assert property (
    $fell(scl) |=> !scl [*8])
    else $error("clock low phase too short");
endmodule
